// ==== hw/ltcb_pkg.sv ====
// ltcb_pkg: shared constants and types of the ladder timer/counter bank
package ltcb_pkg;

  // ***********************************************************
  // sizes
  // ***********************************************************
  localparam int NUM = 64;                     // timers, and counters
  localparam int IW  = 6;                      // element index width
  localparam int VW  = 16;                     // value / contact word width
  localparam int TW  = 25;                     // time base divider width

  // ***********************************************************
  // time base
  // ***********************************************************
  localparam longint CLK_PS   = 5000;          // mclk period, 200 MHz
  localparam longint TICK_MS  = 100;           // 0.1 s present value step
  localparam int     TICK_CYC = int'((TICK_MS * 64'd1000000000) / CLK_PS);

  // ***********************************************************
  // register map, byte offsets
  // ***********************************************************
  localparam logic [11:0] R_STATUS = 12'h000;  // sweep pending flags
  localparam logic [11:0] R_CLEAR  = 12'h004;  // counter_clear_function
  localparam logic [11:0] R_LDT    = 12'h008;  // load_delay_preset
  localparam logic [11:0] R_LDC    = 12'h00C;  // load_count_preset
  localparam logic [7:0]  R_TBITS  = 8'h04;    // delay_contact_word, 0x040
  localparam logic [7:0]  R_CBITS  = 8'h05;    // event_contact_word, 0x050
  localparam logic [1:0]  RG_REG   = 2'h0;     // control region
  localparam logic [1:0]  RG_TPV   = 2'h1;     // delay_count_array 0x100
  localparam logic [1:0]  RG_CPV   = 2'h2;     // event_count_array 0x200
  localparam int          LD_LSB   = 16;       // value field of a load word

  // ***********************************************************
  // values
  // ***********************************************************
  localparam logic [VW-1:0]  PV_ZERO = 16'h0000;
  localparam logic [VW-1:0]  PV_ONE  = 16'h0001;
  localparam logic [IW-1:0]  IDX_END = 6'h3F;
  localparam logic [NUM-1:0] BIT0    = 64'h0000_0000_0000_0001;
  localparam logic [31:0]    RD_ZERO = 32'h0000_0000;

  // ***********************************************************
  // sequencer states
  // ***********************************************************
  typedef enum logic [2:0] {
    S_INIT, S_IDLE, S_RD, S_EV, S_BACC, S_BDONE
  } ltcb_state_e;

endpackage

// ==== hw/ltcb_mem_if.sv ====
// ltcb_mem_if: access port of one value memory
`timescale 1ns/1ps
`default_nettype none
interface ltcb_mem_if import ltcb_pkg::*; ();
  logic [IW-1:0] addr;
  logic          we;
  logic [VW-1:0] wdata;
  logic [VW-1:0] rdata;
  modport ctl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== hw/ltcb_mem.sv ====
// ltcb_mem: 64 x 16 value memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module ltcb_mem import ltcb_pkg::*; (
  // clock
  input wire logic mclk,
  // access port
  ltcb_mem_if.mem  port
);

  logic [VW-1:0] store [NUM];

  // read first: a write cycle returns the old word, read data registered
  always_ff @(posedge mclk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    port.rdata <= store[port.addr];
  end

endmodule
`default_nettype wire

// ==== hw/ltcb_top.sv ====
// ltcb_top: bank of 64 delay timers and 64 event counters on AHB-Lite
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - a timer whose coil rises loads its preset and closes its contact once that runs out.
// - an expired timer keeps its contact closed until the coil drops, then opens it.
// - a coil that drops while the timer runs stops it and the contact stays open.
// - a new coil rise always reloads the full preset, never a leftover count.
// - the first counter coil rise after a clear loads preset minus one.
// - each later coil rise takes exactly one off the count.
// - a coil that stays on adds no further steps; only rises count.
// - a count of zero sets the counter contact, which then ignores the coil.
// - only the counter clear drops that contact and returns the counter to its reset state.
// - there are 64 timers and 64 counters, each with own coil, contact, preset and count.
// - every present value is read and written by index on the bus.
// - contacts are read in 16-bit words, four for timers and four for counters.
// - a load word of index and value replaces one preset at run time.
// - writing a timer present value starts it, one count per tenth of a second.
// - writing a counter present value takes effect at once, as is.
module ltcb_top import ltcb_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           rst,
  // ahb-lite slave
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata,
  // ladder scan side
  input  wire logic           scan_mark,
  input  wire logic [NUM-1:0] timer_coil,
  input  wire logic [NUM-1:0] counter_coil,
  output logic [NUM-1:0]      delay_contact_word,
  output logic [NUM-1:0]      event_contact_word
);

  // ***********************************************************
  // state
  // ***********************************************************
  ltcb_state_e    st;
  ltcb_state_e    next_st;
  logic [IW-1:0]  idx;
  logic           scan_sw;
  logic           tick_sw;
  logic           scan_pend;
  logic           tick_pend;
  logic [TW-1:0]  tdiv;
  logic           tick;
  logic           b_pend;
  logic           b_wr;
  logic [11:0]    b_addr;
  logic [NUM-1:0] t_now;
  logic [NUM-1:0] c_now;
  logic [NUM-1:0] t_prev;
  logic [NUM-1:0] c_prev;
  logic [NUM-1:0] t_run;
  logic [NUM-1:0] c_arm;
  logic [NUM-1:0] clr_pend;
  logic [NUM-1:0] tc_s1;
  logic [NUM-1:0] tc_s2;
  logic [NUM-1:0] tc_s3;
  logic [NUM-1:0] tc_f;
  logic [NUM-1:0] cc_s1;
  logic [NUM-1:0] cc_s2;
  logic [NUM-1:0] cc_s3;
  logic [NUM-1:0] cc_f;
  logic           sc_s1;
  logic           sc_s2;
  logic           sc_s3;
  logic           sc_f;
  logic           sc_fq;

  // ***********************************************************
  // value memories: present values and presets
  // ***********************************************************
  ltcb_mem_if m_tpv ();
  ltcb_mem_if m_tsv ();
  ltcb_mem_if m_cpv ();
  ltcb_mem_if m_csv ();
  ltcb_mem u_tpv (.mclk(mclk), .port(m_tpv.mem));
  ltcb_mem u_tsv (.mclk(mclk), .port(m_tsv.mem));
  ltcb_mem u_cpv (.mclk(mclk), .port(m_cpv.mem));
  ltcb_mem u_csv (.mclk(mclk), .port(m_csv.mem));

  // ***********************************************************
  // bus decode
  // ***********************************************************
  wire logic          capture = hsel & htrans[1] & hready;
  wire logic [IW-1:0] b_idx   = b_addr[IW+1:2];
  wire logic [1:0]    b_rg    = b_addr[9:8];
  wire logic          b_acc   = (st == S_BACC);
  wire logic          b_we    = b_acc & b_wr;
  wire logic [IW-1:0] w_idx   = hwdata[IW-1:0];
  wire logic [VW-1:0] w_val   = hwdata[LD_LSB +: VW];
  wire logic [VW-1:0] w_low   = hwdata[VW-1:0];
  wire logic          w_tpv   = b_we & (b_rg == RG_TPV);
  wire logic          w_cpv   = b_we & (b_rg == RG_CPV);
  wire logic          w_ldt   = b_we & (b_addr == R_LDT);
  wire logic          w_ldc   = b_we & (b_addr == R_LDC);
  wire logic          w_clr   = b_we & (b_addr == R_CLEAR);
  wire logic          init    = (st == S_INIT);
  wire logic          ev      = (st == S_EV);
  wire logic          start   = (st == S_IDLE) & ~b_pend & (scan_pend | tick_pend);

  // ***********************************************************
  // element evaluation for index idx
  // ***********************************************************
  wire logic [VW-1:0] tpv    = m_tpv.rdata;
  wire logic [VW-1:0] tsv    = m_tsv.rdata;
  wire logic [VW-1:0] cpv    = m_cpv.rdata;
  wire logic [VW-1:0] csv    = m_csv.rdata;
  wire logic          t_rise = scan_sw & t_now[idx] & ~t_prev[idx];
  wire logic          t_fall = scan_sw & ~t_now[idx] & t_prev[idx];
  wire logic          t_exp  = t_run[idx] & tick_sw & (tpv <= PV_ONE);
  wire logic          t_dec  = t_run[idx] & tick_sw & ~t_exp;
  wire logic          c_clr  = clr_pend[idx];
  wire logic          c_rise = scan_sw & c_now[idx] & ~c_prev[idx];
  wire logic          c_load = c_rise & ~c_arm[idx];
  wire logic          c_step = c_rise & c_arm[idx] & (cpv != PV_ZERO);

  // timer: a rise reloads the preset, a fall aborts and zeroes
  wire logic [VW-1:0] t_pv_n   = t_fall ? PV_ZERO :
                                 t_rise ? tsv :
                                 t_dec  ? tpv - PV_ONE :
                                 t_exp  ? PV_ZERO : tpv;
  wire logic          t_run_n  = t_fall ? 1'b0 :
                                 t_rise ? (tsv != PV_ZERO) :
                                 t_run[idx] & ~t_exp;
  wire logic          t_done_n = t_fall ? 1'b0 :
                                 t_rise ? (tsv == PV_ZERO) :
                                 delay_contact_word[idx] | t_exp;

  // counter: first rise loads preset-1, later rises step by one
  wire logic [VW-1:0] c_ld_v   = (csv == PV_ZERO) ? PV_ZERO : csv - PV_ONE;
  wire logic [VW-1:0] c_pv_n   = c_clr  ? PV_ZERO :
                                 c_load ? c_ld_v :
                                 c_step ? cpv - PV_ONE : cpv;
  wire logic          c_arm_n  = ~c_clr & (c_arm[idx] | c_rise);
  wire logic          c_done_n = ~c_clr & (event_contact_word[idx] |
                                 (c_arm_n & (c_pv_n == PV_ZERO)));

  // ***********************************************************
  // memory port steering: bus has the port only in S_BACC
  // ***********************************************************
  assign m_tpv.addr  = b_acc ? b_idx : idx;
  assign m_cpv.addr  = b_acc ? b_idx : idx;
  assign m_tsv.addr  = b_acc ? w_idx : idx;
  assign m_csv.addr  = b_acc ? w_idx : idx;
  assign m_tpv.we    = w_tpv | ev | init;
  assign m_cpv.we    = w_cpv | ev | init;
  assign m_tsv.we    = w_ldt | init;
  assign m_csv.we    = w_ldc | init;
  assign m_tpv.wdata = init ? PV_ZERO : (b_acc ? w_low : t_pv_n);
  assign m_cpv.wdata = init ? PV_ZERO : (b_acc ? w_low : c_pv_n);
  assign m_tsv.wdata = init ? PV_ZERO : w_val;
  assign m_csv.wdata = init ? PV_ZERO : w_val;

  // ***********************************************************
  // read data mux
  // ***********************************************************
  wire logic [5:0]    cw_base = {b_addr[3:2], 4'h0};
  wire logic [VW-1:0] t_word  = delay_contact_word[cw_base +: VW];
  wire logic [VW-1:0] c_word  = event_contact_word[cw_base +: VW];
  wire logic [31:0]   reg_rd  =
    (b_addr == R_STATUS)   ? {30'h0, tick_pend, scan_pend} :
    (b_addr[11:4] == R_TBITS) ? {16'h0000, t_word} :
    (b_addr[11:4] == R_CBITS) ? {16'h0000, c_word} : RD_ZERO;
  wire logic [31:0]   rd_mux  =
    (b_rg == RG_TPV) ? {16'h0000, tpv} :
    (b_rg == RG_CPV) ? {16'h0000, cpv} :
    (b_rg == RG_REG) ? reg_rd : RD_ZERO;

  // ***********************************************************
  // sequencer
  // ***********************************************************
  always_comb begin
    next_st = st;
    case (st)
      S_INIT:  next_st = (idx == IDX_END) ? S_IDLE : S_INIT;
      S_IDLE: begin
        if (b_pend) begin
          next_st = S_BACC;
        end else if (scan_pend | tick_pend) begin
          next_st = S_RD;
        end
      end
      S_RD:    next_st = S_EV;
      S_EV:    next_st = (idx == IDX_END) ? S_IDLE : S_RD;
      S_BACC:  next_st = S_BDONE;
      S_BDONE: next_st = S_IDLE;
      default: next_st = S_IDLE;
    endcase
  end

  // state and element index
  always_ff @(posedge mclk) begin
    if (rst) begin
      st  <= S_INIT;
      idx <= '0;
    end else begin
      st <= next_st;
      if (init | ev) begin
        idx <= idx + 6'h01;
      end
    end
  end

  // ***********************************************************
  // pin synchronisers: three flops, accept when 2nd and 3rd agree
  // ***********************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      {tc_s1, tc_s2, tc_s3, tc_f} <= '0;
      {cc_s1, cc_s2, cc_s3, cc_f} <= '0;
      {sc_s1, sc_s2, sc_s3, sc_f, sc_fq} <= '0;
    end else begin
      {tc_s3, tc_s2, tc_s1} <= {tc_s2, tc_s1, timer_coil};
      {cc_s3, cc_s2, cc_s1} <= {cc_s2, cc_s1, counter_coil};
      {sc_s3, sc_s2, sc_s1} <= {sc_s2, sc_s1, scan_mark};
      tc_f  <= (tc_s2 & tc_s3) | (tc_f & (tc_s2 | tc_s3));
      cc_f  <= (cc_s2 & cc_s3) | (cc_f & (cc_s2 | cc_s3));
      sc_f  <= (sc_s2 & sc_s3) | (sc_f & (sc_s2 | sc_s3));
      sc_fq <= sc_f;
    end
  end

  // ***********************************************************
  // 0.1 s time base and sweep requests
  // ***********************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      tdiv <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tdiv == TW'(TICK_CYCLES - 1));
      tdiv <= (tdiv == TW'(TICK_CYCLES - 1)) ? '0 : tdiv + 25'h0000001;
    end
  end

  // request flags: a new request wins over the start that clears it
  always_ff @(posedge mclk) begin
    if (rst) begin
      scan_pend <= 1'b0;
      tick_pend <= 1'b0;
      scan_sw   <= 1'b0;
      tick_sw   <= 1'b0;
      t_now     <= '0;
      c_now     <= '0;
    end else begin
      scan_pend <= (sc_f & ~sc_fq) | (scan_pend & ~start);
      tick_pend <= tick | (tick_pend & ~start);
      if (start) begin
        scan_sw <= scan_pend;
        tick_sw <= tick_pend;
      end
      if (start & scan_pend) begin
        t_now <= tc_f;
        c_now <= cc_f;
      end
    end
  end

  // ***********************************************************
  // per-element flags
  // ***********************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      {t_prev, c_prev, t_run, c_arm} <= '0;
      delay_contact_word <= '0;
      event_contact_word <= '0;
    end else begin
      if (ev) begin
        t_run[idx]              <= t_run_n;
        delay_contact_word[idx] <= t_done_n;
        c_arm[idx]              <= c_arm_n;
        event_contact_word[idx] <= c_done_n;
        if (scan_sw) begin
          t_prev[idx] <= t_now[idx];
          c_prev[idx] <= c_now[idx];
        end
      end
      if (w_tpv) begin
        t_run[b_idx]              <= 1'b1;
        delay_contact_word[b_idx] <= 1'b0;
      end
      if (w_cpv) begin
        c_arm[b_idx] <= 1'b1;
      end
    end
  end

  // clear requests: a new request wins over the sweep that applies one
  wire logic [NUM-1:0] clr_set = w_clr ? (BIT0 << w_idx) : '0;
  wire logic [NUM-1:0] clr_ack = ev ? (BIT0 << idx) : '0;
  always_ff @(posedge mclk) begin
    if (rst) begin
      clr_pend <= '0;
    end else begin
      clr_pend <= (clr_pend & ~clr_ack) | clr_set;
    end
  end

  // ***********************************************************
  // bus slave: wait states until the sequencer grants the port
  // ***********************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      b_pend    <= 1'b0;
      b_wr      <= 1'b0;
      b_addr    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= '0;
    end else begin
      if (capture) begin
        b_pend    <= 1'b1;
        b_wr      <= hwrite;
        b_addr    <= haddr[11:0];
        hreadyout <= 1'b0;
      end else if (st == S_BDONE) begin
        b_pend    <= 1'b0;
        hreadyout <= 1'b1;
        if (!b_wr) begin
          hrdata <= rd_mux;
        end
      end
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_wait;
    !hreadyout ##[1:300] hreadyout;
  endsequence

  a_bus_answer: assert property (capture |=> s_wait)
    else $error("bus transfer not answered");
  a_tmr_rise_run: assert property (
    ev && t_rise && (tsv != PV_ZERO) |=>
      t_run[$past(idx)] && !delay_contact_word[$past(idx)])
    else $error("timer did not start on coil rise");
  a_tmr_fall_open: assert property (
    ev && t_fall |=> !delay_contact_word[$past(idx)])
    else $error("timer contact stayed closed after coil fall");
  a_tmr_abort: assert property (
    ev && t_fall |=> !t_run[$past(idx)] ##1 !delay_contact_word[$past(idx, 2)])
    else $error("aborted timer kept running");
  a_tmr_reload: assert property (
    ev && t_rise |-> m_tpv.we && (m_tpv.wdata == tsv))
    else $error("timer did not reload full preset");
  a_ctr_first: assert property (
    ev && c_load && !c_clr && (csv != PV_ZERO) |-> m_cpv.wdata == csv - PV_ONE)
    else $error("counter first load not preset minus one");
  a_ctr_step: assert property (
    ev && c_rise && c_arm[idx] && !c_clr && (cpv != PV_ZERO)
      |-> m_cpv.wdata == cpv - PV_ONE)
    else $error("counter did not step by one");
  a_ctr_level: assert property (
    ev && !c_rise && !c_clr |-> m_cpv.wdata == cpv)
    else $error("counter moved without a coil rise");
  a_ctr_sticky: assert property (
    ev && !c_clr && event_contact_word[idx] |=> event_contact_word[$past(idx)])
    else $error("counter contact dropped without clear");
  a_ctr_clear: assert property (
    ev && c_clr |=> !event_contact_word[$past(idx)] && !c_arm[$past(idx)])
    else $error("counter clear not applied");
  a_tmr_write: assert property (
    w_tpv |=> t_run[$past(b_idx)])
    else $error("present value write did not start timer");
  a_tick_gap: assert property (
    tick |=> !tick [*8])
    else $error("time base ticks too close");
  a_scan_snap: assert property (
    start && scan_pend |=> (t_now == $past(tc_f)) && scan_sw)
    else $error("coil snapshot not taken at scan");

endmodule
`default_nettype wire

// ==== test/ltcb_scan_model.sv ====
// ltcb_scan_model: ladder program scan that drives the scan mark and coil pins
`timescale 1ns/1ps
`default_nettype none
module ltcb_scan_model #(
  parameter int SCAN_CYC = 300
) (
  // clock
  input  wire logic        mclk,
  // coil images the program wants
  input  wire logic [63:0] t_want,
  input  wire logic [63:0] c_want,
  // pins
  output logic             scan_mark,
  output logic [63:0]      timer_coil,
  output logic [63:0]      counter_coil
);
  int cnt;

  initial begin
    cnt = 0;
    scan_mark = 1'b0;
    timer_coil = 64'h0;
    counter_coil = 64'h0;
  end

  // one scan mark per program scan, coils move mid scan away from the mark
  always @(posedge mclk) begin
    cnt <= (cnt == SCAN_CYC - 1) ? 0 : cnt + 1;
    scan_mark <= (cnt < 16);
    if (cnt == SCAN_CYC / 2) begin
      timer_coil <= t_want;
      counter_coil <= c_want;
    end
  end
endmodule
`default_nettype wire

// ==== test/ladder_timer_counter_bank_tb.sv ====
// ladder_timer_counter_bank_tb: bus and scan tests of the timer/counter bank
`timescale 1ns/1ps
`default_nettype none
module ladder_timer_counter_bank_tb;
  import ltcb_pkg::*;
  localparam int TK = 400;  // shortened tick period
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              hsel = 1'b0;
  logic              hwrite = 1'b0;
  logic [31:0]       haddr = 32'h0;
  logic [31:0]       hwdata = 32'h0;
  logic [31:0]       rd;
  logic [1:0]        htrans = 2'h0;
  logic [2:0]        hsize = 3'h2;
  logic [63:0]       t_want = 64'h0;
  logic [63:0]       c_want = 64'h0;
  wire logic         hreadyout;
  wire logic         hresp;
  wire logic [31:0]  hrdata;
  wire logic         scan_mark;
  wire logic [63:0]  timer_coil;
  wire logic [63:0]  counter_coil;
  wire logic [63:0]  dcw;
  wire logic [63:0]  ecw;
  int                miscompares = 0;
  int                num_checks = 0;

  ltcb_top #(.TICK_CYCLES(TK)) uut (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .scan_mark(scan_mark), .timer_coil(timer_coil), .counter_coil(counter_coil),
    .delay_contact_word(dcw), .event_contact_word(ecw)
  );

  ltcb_scan_model #(.SCAN_CYC(300)) model (
    .mclk(mclk), .t_want(t_want), .c_want(c_want), .scan_mark(scan_mark),
    .timer_coil(timer_coil), .counter_coil(counter_coil)
  );

  // 200 MHz clock
  initial begin
    forever #2.5 mclk = ~mclk;
  end

  // verdict and end of run
  task automatic end_sim;
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one single ahb-lite transfer, waits out wait states
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  // one coil pulse of counter 64 spanning whole scans
  task automatic pulse;
    c_want[63] <= 1'b1;
    wt(600);
    c_want[63] <= 1'b0;
    wt(600);
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rdchk("tword0", 32'h40, 32'h0);
    rdchk("unmapped", 32'h300, 32'h0);
    // timer 1, preset 8 ticks
    xfer(1'b1, 32'h8, 32'h0008_0000);
    t_want[0] <= 1'b1;
    wt(2000);
    chk("t1 early", {31'h0, dcw[0]}, 32'h0);
    wt(2000);
    chk("t1 closed", {31'h0, dcw[0]}, 32'h1);
    t_want[0] <= 1'b0;
    wt(700);
    chk("t1 open", {31'h0, dcw[0]}, 32'h0);
    t_want[0] <= 1'b1;
    wt(1800);
    t_want[0] <= 1'b0;
    wt(4000);
    chk("t1 abort", {31'h0, dcw[0]}, 32'h0);
    t_want[0] <= 1'b1;
    wt(2000);
    chk("t1 restart", {31'h0, dcw[0]}, 32'h0);
    wt(2000);
    chk("t1 reclosed", {31'h0, dcw[0]}, 32'h1);
    t_want[0] <= 1'b0;
    // counter 64, preset 3
    xfer(1'b1, 32'hC, 32'h0003_003F);
    pulse();
    rdchk("c64 first", 32'h2FC, 32'h2);
    c_want[63] <= 1'b1;
    wt(750);
    rdchk("c64 second", 32'h2FC, 32'h1);
    wt(1200);
    rdchk("c64 held", 32'h2FC, 32'h1);
    c_want[63] <= 1'b0;
    wt(600);
    pulse();
    rdchk("c64 zero", 32'h2FC, 32'h0);
    chk("c64 contact", {31'h0, ecw[63]}, 32'h1);
    rdchk("cword3", 32'h5C, 32'h8000);
    pulse();
    chk("c64 sticky", {31'h0, ecw[63]}, 32'h1);
    xfer(1'b1, 32'h4, 32'h3F);
    wt(600);
    chk("c64 cleared", {31'h0, ecw[63]}, 32'h0);
    pulse();
    rdchk("c64 reload", 32'h2FC, 32'h2);
    // present values from script
    xfer(1'b1, 32'h224, 32'h7);
    rdchk("c10 pv", 32'h224, 32'h7);
    xfer(1'b1, 32'h224, 32'h6);
    rdchk("c10 step", 32'h224, 32'h6);
    xfer(1'b1, 32'h104, 32'h3);
    wt(600);
    chk("t2 running", {31'h0, dcw[1]}, 32'h0);
    wt(900);
    chk("t2 closed", {31'h0, dcw[1]}, 32'h1);
    rdchk("tword0 t2", 32'h40, 32'h2);
    rdchk("t2 pv", 32'h104, 32'h0);
    end_sim();
  end

  // watchdog against a hung bus or scan
  initial begin
    wt(60000);
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
